// ### pkg/urx_pkg.sv
// Package for the UART receive status, error and interrupt block.
// Assumes a 32-bit classic Wishbone slave port and a 250 MHz core clock.
package urx_pkg;

  // Register byte offsets
  localparam logic [7:0] URX_STATUS_OFF = 8'h00;
  localparam logic [7:0] URX_DATA_OFF = 8'h04;
  localparam logic [7:0] URX_CTRL_OFF = 8'h08;
  localparam logic [7:0] URX_FIFO_CTRL_OFF = 8'h0c;
  localparam logic [7:0] URX_COUNT_OFF = 8'h10;

  // Status bit positions
  localparam int URX_ST_RXF = 0;
  localparam int URX_ST_OVR = 1;
  localparam int URX_ST_NOISE = 2;
  localparam int URX_ST_FRAME = 3;
  localparam int URX_ST_PAR = 4;
  localparam int URX_ST_TXE = 5;
  localparam int URX_ST_TXI = 6;

  // Receive FIFO geometry
  localparam int URX_FIFO_DEPTH = 4;
  localparam int URX_PTR_W = 2;
  localparam int URX_CNT_W = 3;
  localparam int URX_WORD_W = 9;

  // Parity type encoding
  localparam logic [1:0] URX_PAR_EVEN = 2'h0;
  localparam logic [1:0] URX_PAR_ODD = 2'h1;
  localparam logic [1:0] URX_PAR_MARK = 2'h2;
  localparam logic [1:0] URX_PAR_SPACE = 2'h3;

  // Reset values and control write mask
  localparam logic [15:0] URX_CTRL_RESET = 16'h0000;
  localparam logic [15:0] URX_CTRL_WMASK = 16'h3fff;
  localparam logic [1:0] URX_TRIG_RESET = 2'h0;

  // Wake-up settling time and its cycle count (rounded up)
  localparam int URX_CLK_PERIOD_PS = 4000;
  localparam int URX_WAKE_SETTLE_NS = 1000;
  localparam int URX_WAKE_SETTLE_CYC = (URX_WAKE_SETTLE_NS * 1000 + URX_CLK_PERIOD_PS - 1) / URX_CLK_PERIOD_PS;
  localparam int URX_SETTLE_W = 16;

  // Software control bits, one 16-bit word
  typedef struct packed {
    logic [1:0] spare;
    logic uart_irq_enable;
    logic global_irq_enable;
    logic pin_resume_enable;
    logic tx_idle_ie;
    logic tx_empty_ie;
    logic rx_int_enable;
    logic addr_detect_enable;
    logic two_stop;
    logic nine_bit_select;
    logic [1:0] parity_type;
    logic parity_enable;
    logic rx_enable;
    logic uart_master_enable;
  } urx_ctrl_s;

  // One received frame from the shift core
  typedef struct packed {
    logic [URX_WORD_W-1:0] word;
    logic parity_bit;
    logic stop1;
    logic stop2;
    logic noise;
  } urx_frame_s;

  // One FIFO entry: word plus the flags that belong to it
  typedef struct packed {
    logic [URX_WORD_W-1:0] word;
    logic framing;
    logic parity;
  } urx_entry_s;

endpackage

// ### rtl/urx_status_irq.sv
// UART receive status, error flags, 4-entry receive FIFO, interrupt pulse and pin wake-up.
// Assumes a receive shift core delivering whole frames, and fH run state given as an enable.
//
// Functional notes
// [R01] Word moved into buffer sets data flag; interrupt if receive enable set. Code also needs FIFO count at least trig + 1.
// [R02] Overrun also raises receive interrupt when receive interrupt enable set.
// [R03] Buffer is a four-byte FIFO; fifth byte may still shift in.
// [R04] Fifth byte with FIFO full sets overrun, FIFO kept, shift register lost.
// [R05] Overrun clears only after status access then data buffer read.
// [R06] Noisy frame still stored; noise flag rises with data flag, no own interrupt.
// [R07] Noise flag clears on status read followed by data buffer read.
// [R08] Framing flag set when any expected stop bit samples low.
// [R09] Framing flag stored with its word; cleared on reset.
// [R10] Parity flag set on wrong parity when enabled, per type; cleared on reset.
// [R11] Software reads framing and parity flags before reading the data word.
// [R12] Interrupt is a low pulse for tx empty, tx idle, rx, overrun, address, wake.
// [R13] Each tx source has own enable; both rx sources share one enable.
// [R14] Status flags read-only, cleared only by defined access sequences.
// [R15] Address detect: data interrupt only when top received bit is high.
// [R16] Without address detect, every data flag set requests an interrupt. Code requests one only once FIFO count reaches trig + 1.
// [R17] Software clears parity enable whenever address detect is enabled.
// [R18] With UART clock stopped, reception freezes and later resumes.
// [R19] Idle or sleep leaves all registers unchanged.
// [R20] Clock off plus all wake enables: falling receive-pin edge raises wake interrupt.
// [R21] Data during settling ignored; wake interrupt held until settling ends.
// [R22] Global or UART interrupt enable clear: edge only wakes, no interrupt.
// [R23] Falling-edge wake detect works while the UART clock is stopped.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module urx_status_irq
  import urx_pkg::*;
#(
  parameter int SETTLE_CYC = URX_WAKE_SETTLE_CYC
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive shift core
  input wire logic rx_done_i,
  input wire urx_frame_s rx_frame_i,
  output logic rx_core_enable_o,
  // Transmitter state levels
  input wire logic tx_empty_i,
  input wire logic tx_idle_i,
  // Clock gating and pin
  input wire logic uart_clk_run_i,
  input wire logic rx_pin_i,
  // Requests to the system
  output logic irq_n_o,
  output logic wake_o
);

  // Whole module state
  typedef struct packed {
    urx_ctrl_s ctrl;
    logic [1:0] trig;
    urx_entry_s [URX_FIFO_DEPTH-1:0] fifo;
    logic [URX_PTR_W-1:0] wp;
    logic [URX_PTR_W-1:0] rp;
    logic [URX_CNT_W-1:0] cnt;
    logic ovr;
    logic noise;
    logic armed;
    logic rx_prev;
    logic wake_pend;
    logic settling;
    logic [URX_SETTLE_W-1:0] settle;
    logic tx_empty_prev;
    logic tx_idle_prev;
    logic ack;
    logic [31:0] rdata;
    logic irq_n;
    logic wake;
    logic core_en;
  } urx_state_s;

  localparam logic [URX_SETTLE_W-1:0] SETTLE_LOAD = URX_SETTLE_W'(SETTLE_CYC);
  localparam logic [URX_SETTLE_W-1:0] SETTLE_ONE = 16'h0001;
  localparam logic [URX_CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [URX_CNT_W-1:0] CNT_FULL = URX_CNT_W'(URX_FIFO_DEPTH);
  localparam logic [URX_PTR_W-1:0] PTR_ONE = 2'h1;

  urx_state_s s;
  urx_state_s next_s;

  // Bus decode and frame checks
  logic req;
  logic rd_status;
  logic rd_data;
  logic any_status;
  logic top_bit;
  logic par_expect;
  logic par_bad;
  logic frame_bad;
  logic accept;
  logic pop;
  logic push;
  logic overrun_ev;
  logic rx_ev;
  logic tx_ev;
  logic wake_ev;
  logic fall;
  logic [URX_CNT_W-1:0] cnt_after_pop;
  logic [URX_CNT_W-1:0] cnt_new;
  logic [URX_CNT_W-1:0] trig_cnt;
  logic [15:0] ctrl_bits;
  logic [15:0] wr_bits;
  logic [URX_WORD_W-1:0] word_m;
  urx_entry_s head;

  // Combinational next state
  always_comb
  begin
    next_s = s;
    req = wb_cyc_i && wb_stb_i && !s.ack;
    any_status = req && (wb_adr_i == URX_STATUS_OFF);
    rd_status = any_status && !wb_we_i;
    rd_data = req && !wb_we_i && (wb_adr_i == URX_DATA_OFF);
    head = s.fifo[s.rp];

    // Word length masking and top bit selection
    word_m = s.ctrl.nine_bit_select ? rx_frame_i.word : {1'b0, rx_frame_i.word[7:0]};
    top_bit = s.ctrl.nine_bit_select ? rx_frame_i.word[8] : rx_frame_i.word[7];

    // Parity check by type
    case (s.ctrl.parity_type)
      URX_PAR_EVEN: par_expect = ^word_m;
      URX_PAR_ODD: par_expect = ~^word_m;
      URX_PAR_MARK: par_expect = 1'b1;
      URX_PAR_SPACE: par_expect = 1'b0;
      default: par_expect = 1'b0;
    endcase
    par_bad = s.ctrl.parity_enable && (rx_frame_i.parity_bit != par_expect); // [R10]
    frame_bad = !rx_frame_i.stop1 || (s.ctrl.two_stop && !rx_frame_i.stop2); // [R08]

    // Frames count only while fH runs and settling is over
    accept = rx_done_i && uart_clk_run_i && !s.settling && s.ctrl.uart_master_enable && s.ctrl.rx_enable; // [R18] [R21]

    // A pop frees its slot before a push in the same cycle is judged
    pop = rd_data && (s.cnt != '0);
    cnt_after_pop = pop ? s.cnt - CNT_ONE : s.cnt;
    push = accept && (cnt_after_pop != CNT_FULL); // [R03]
    overrun_ev = accept && (cnt_after_pop == CNT_FULL); // [R04]
    cnt_new = push ? cnt_after_pop + CNT_ONE : cnt_after_pop;
    trig_cnt = {1'b0, s.trig} + CNT_ONE;

    // FIFO pointers; contents untouched on overrun
    if (pop)
    begin
      next_s.rp = s.rp + PTR_ONE;
    end
    if (push)
    begin
      next_s.fifo[s.wp] = '{word: word_m, framing: frame_bad, parity: par_bad}; // [R09]
      next_s.wp = s.wp + PTR_ONE;
    end
    next_s.cnt = cnt_new; // [R01]

    // Status access then data read clears sticky flags; set wins
    if (any_status)
    begin
      next_s.armed = 1'b1;
    end
    if (rd_data)
    begin
      next_s.armed = 1'b0;
      if (s.armed)
      begin
        next_s.ovr = 1'b0; // [R05]
        next_s.noise = 1'b0; // [R07]
      end
    end
    if (overrun_ev)
    begin
      next_s.ovr = 1'b1; // [R04]
    end
    if (push && rx_frame_i.noise)
    begin
      next_s.noise = 1'b1; // [R06]
    end

    // Register writes; status is read-only
    ctrl_bits = s.ctrl;
    wr_bits = ctrl_bits;
    if (req && wb_we_i && wb_adr_i == URX_CTRL_OFF)
    begin
      if (wb_sel_i[0])
      begin
        wr_bits[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1])
      begin
        wr_bits[15:8] = wb_dat_i[15:8];
      end
    end
    next_s.ctrl = urx_ctrl_s'(wr_bits & URX_CTRL_WMASK); // [R14]
    if (req && wb_we_i && wb_adr_i == URX_FIFO_CTRL_OFF && wb_sel_i[0])
    begin
      next_s.trig = wb_dat_i[1:0];
    end

    // Read data and one-cycle ack; unmapped reads give zero
    next_s.ack = req;
    next_s.rdata = '0;
    if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        URX_STATUS_OFF:
        begin
          next_s.rdata[URX_ST_RXF] = (s.cnt != '0);
          next_s.rdata[URX_ST_OVR] = s.ovr;
          next_s.rdata[URX_ST_NOISE] = s.noise;
          next_s.rdata[URX_ST_FRAME] = (s.cnt != '0) && head.framing;
          next_s.rdata[URX_ST_PAR] = (s.cnt != '0) && head.parity;
          next_s.rdata[URX_ST_TXE] = tx_empty_i;
          next_s.rdata[URX_ST_TXI] = tx_idle_i;
        end
        URX_DATA_OFF: next_s.rdata[URX_WORD_W-1:0] = (s.cnt != '0) ? head.word : '0;
        URX_CTRL_OFF: next_s.rdata[15:0] = ctrl_bits;
        URX_FIFO_CTRL_OFF: next_s.rdata[1:0] = s.trig;
        URX_COUNT_OFF: next_s.rdata[URX_CNT_W-1:0] = s.cnt;
        default: next_s.rdata = '0;
      endcase
    end

    // Pin edge sampled on the core clock, which runs while fH is stopped
    next_s.rx_prev = rx_pin_i;
    fall = s.rx_prev && !rx_pin_i; // [R23]
    next_s.wake = 1'b0;
    if (!uart_clk_run_i && fall && s.ctrl.pin_resume_enable && s.ctrl.uart_master_enable &&
        s.ctrl.rx_enable && s.ctrl.rx_int_enable)
    begin
      next_s.wake_pend = 1'b1; // [R20]
      next_s.wake = !s.wake_pend;
    end

    // Settling window after fH returns
    wake_ev = 1'b0;
    if (uart_clk_run_i && s.wake_pend)
    begin
      next_s.wake_pend = 1'b0;
      next_s.settling = 1'b1;
      next_s.settle = SETTLE_LOAD;
    end
    else if (s.settling)
    begin
      if (s.settle <= SETTLE_ONE)
      begin
        next_s.settling = 1'b0;
        wake_ev = 1'b1; // [R21]
      end
      else
      begin
        next_s.settle = s.settle - SETTLE_ONE;
      end
    end

    // Interrupt sources: tx rising levels with own enables, rx shared enable
    next_s.tx_empty_prev = tx_empty_i;
    next_s.tx_idle_prev = tx_idle_i;
    tx_ev = (tx_empty_i && !s.tx_empty_prev && s.ctrl.tx_empty_ie) ||
            (tx_idle_i && !s.tx_idle_prev && s.ctrl.tx_idle_ie); // [R13]
    rx_ev = s.ctrl.rx_int_enable && ((push && (cnt_new >= trig_cnt) &&
            (!s.ctrl.addr_detect_enable || top_bit)) || overrun_ev); // [R01] [R02] [R13] [R15] [R16]

    // One low cycle per event, only with both global enables
    next_s.irq_n = !((tx_ev || rx_ev || wake_ev) && s.ctrl.global_irq_enable && s.ctrl.uart_irq_enable); // [R12] [R22]

    // Shift core runs only with fH, enables, and after settling
    next_s.core_en = uart_clk_run_i && s.ctrl.uart_master_enable && s.ctrl.rx_enable && !s.settling; // [R18]
  end

  // State register; fH stop leaves the software registers untouched, only core enable and wake state follow it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0; // [R09] [R10]
      s.ctrl <= urx_ctrl_s'(URX_CTRL_RESET);
      s.trig <= URX_TRIG_RESET;
      s.rx_prev <= 1'b1;
      s.irq_n <= 1'b1;
    end
    else
    begin
      s <= next_s; // [R19]
    end
  end

  // Outputs straight from flops
  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign irq_n_o = s.irq_n;
  assign wake_o = s.wake;
  assign rx_core_enable_o = s.core_en;

endmodule // urx_status_irq

// ### tb/urx_checker.sv
// Port-level checker for the receive status and interrupt block.
// Assumes the bench holds both transmitter level inputs low.
`timescale 1ns/1ps
module urx_checker
  import urx_pkg::*;
#(
  parameter int SETTLE_CYC = 4
)
(
  // Watched ports, grouped to save room
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic rx_done_i, rx_core_enable_o, tx_empty_i, tx_idle_i,
  input wire urx_frame_s rx_frame_i,
  input wire logic uart_clk_run_i, rx_pin_i, irq_n_o, wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic woke;
  // Wake edge seen, kept until fH returns
  always_ff @(posedge clk_i)
    if (rst_i)
      woke <= 1'b0;
    else if (wake_o)
      woke <= 1'b1;
    else if ($rose(uart_clk_run_i))
      woke <= 1'b0;
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_irq_pulse: assert property (!irq_n_o |=> irq_n_o)
    else $error("interrupt low longer than one cycle");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  a_wake_cause: assert property (wake_o |-> $past(!uart_clk_run_i) && $past(!rx_pin_i) && $past(rx_pin_i, 2))
    else $error("wake without falling pin while clock off");
  a_core_frozen: assert property (!uart_clk_run_i |=> !rx_core_enable_o)
    else $error("receive core runs while clock off");
  a_quiet_off: assert property (!uart_clk_run_i && !$past(uart_clk_run_i) |-> irq_n_o)
    else $error("interrupt while clock off");
  a_settle_hold: assert property ($rose(uart_clk_run_i) && woke |-> irq_n_o [*5])
    else $error("wake interrupt before settling ends");
  // Main scenarios reached
  c_wake: cover property (wake_o);
  c_irq: cover property (!irq_n_o);
  c_resume: cover property ($rose(uart_clk_run_i) && woke);
endmodule // urx_checker

bind urx_status_irq urx_checker #(.SETTLE_CYC(SETTLE_CYC)) i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .rx_done_i, .rx_core_enable_o,
  .tx_empty_i, .tx_idle_i, .rx_frame_i, .uart_clk_run_i, .rx_pin_i, .irq_n_o, .wake_o);

// ### tb/urx_frame_src.sv
// Far-side model: delivers whole received frames and drives the pin.
// Assumes the caller runs its tasks from a clocked sequence.
`timescale 1ns/1ps
module urx_frame_src
  import urx_pkg::*;
(
  // Core clock
  input wire logic clk_i,
  // Frame and pin
  output logic done_o,
  output urx_frame_s frame_o,
  output logic pin_o
);
  // Idle pin high, no frame pending
  initial
  begin
    done_o = 1'b0;
    frame_o = '0;
    pin_o = 1'b1;
  end
  // One frame, valid for one cycle only
  task automatic send(input urx_frame_s f);
    @(posedge clk_i);
    done_o <= 1'b1;
    frame_o <= f;
    @(posedge clk_i);
    done_o <= 1'b0;
    frame_o <= ~f; // Stale word never lingers
  endtask
  // Start-bit like low on the pin
  task automatic fall();
    @(posedge clk_i);
    pin_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    pin_o <= 1'b1;
  endtask
endmodule // urx_frame_src

// ### tb/tb_urx_status_irq.sv
// Bench for the receive status block: bus tasks, frame model, wake tests.
// Assumes transmitter levels held low; settling shortened to 4 cycles.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_urx_status_irq;
  import urx_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, rx_done_i, rx_core_enable_o, irq_n_o, wake_o, rx_pin_i, pb;
  logic uart_clk_run_i = 1'b1;
  urx_frame_s rx_frame_i;
  int error_cnt = 0, compares = 0, irqs = 0, wakes = 0, cyc_cnt = 0;
  urx_status_irq #(.SETTLE_CYC(4)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_done_i, .rx_frame_i, .rx_core_enable_o,
    .tx_empty_i(1'b0), .tx_idle_i(1'b0), .uart_clk_run_i, .rx_pin_i, .irq_n_o, .wake_o);
  urx_frame_src i_src (.clk_i, .done_o(rx_done_i), .frame_o(rx_frame_i), .pin_o(rx_pin_i));
  always #2 clk_i = ~clk_i;
  // Pulses counted mid-cycle, away from the launching edge
  always @(negedge clk_i)
  begin
    irqs += (irq_n_o === 1'b0);
    wakes += (wake_o === 1'b1);
  end
  // Hang guard
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Classic cycle: hold until ack seen, release at that edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Ack and read data are taken at the rising edge that samples ack high
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK("reg", e, q)
  endtask
  // Frame in, expected interrupt pulses out
  task automatic fr(input urx_frame_s f, input int n);
    int b;
    b = irqs;
    i_src.send(f);
    repeat (3) @(posedge clk_i);
    `CHK("irq", n, irqs - b)
  endtask
  // Clock off, pin falls, frame dropped, clock back
  task automatic wk(input logic [31:0] c, input int n);
    int b, w;
    wb(1'b1, URX_CTRL_OFF, c);
    b = irqs;
    w = wakes;
    uart_clk_run_i <= 1'b0;
    i_src.fall();
    fr({9'h0cc, 4'b0110}, 0);
    `CHK("wake", 1, wakes - w)
    uart_clk_run_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    `CHK("wirq", n, irqs - b)
    rd(URX_COUNT_OFF, 32'h2);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(URX_CTRL_OFF, 32'h0);
    rd(URX_STATUS_OFF, 32'h0);
    rd(8'h40, 32'h0);
    rd(URX_DATA_OFF, 32'h0);
    wb(1'b1, URX_CTRL_OFF, 32'h3103);
    rd(URX_CTRL_OFF, 32'h3103);
    // Fill four, fifth overruns
    for (int i = 0; i < 4; i++) fr({9'h010 + 9'(i), 4'b0110}, 1);
    fr({9'h0aa, 4'b0110}, 1);
    rd(URX_COUNT_OFF, 32'h4);
    rd(URX_DATA_OFF, 32'h10);
    rd(URX_STATUS_OFF, 32'h03);
    rd(URX_DATA_OFF, 32'h11);
    rd(URX_STATUS_OFF, 32'h01);
    rd(URX_DATA_OFF, 32'h12);
    rd(URX_DATA_OFF, 32'h13);
    // Noise, then framing on second stop bit
    fr({9'h055, 4'b0111}, 1);
    rd(URX_STATUS_OFF, 32'h05);
    rd(URX_DATA_OFF, 32'h55);
    rd(URX_STATUS_OFF, 32'h00);
    wb(1'b1, URX_CTRL_OFF, 32'h3143);
    fr({9'h066, 4'b0100}, 1);
    rd(URX_STATUS_OFF, 32'h09);
    rd(URX_DATA_OFF, 32'h66);
    // Wrong parity bit for each type
    for (int i = 0; i < 4; i++)
    begin
      pb = (i == 1) || (i == 3);
      wb(1'b1, URX_CTRL_OFF, 32'h3107 | (i << 3));
      fr({9'h001, pb, 3'b110}, 1);
      rd(URX_STATUS_OFF, 32'h11);
      rd(URX_DATA_OFF, 32'h01);
    end
    // Address detect, parity off
    wb(1'b1, URX_CTRL_OFF, 32'h3183);
    fr({9'h07f, 4'b0110}, 0);
    fr({9'h080, 4'b0110}, 1);
    rd(URX_STATUS_OFF, 32'h01);
    wk(32'h3903, 1);
    wk(32'h0903, 0);
    final_report();
  end
endmodule // tb_urx_status_irq
